/* dv/baud_assertions.sv */
`timescale 1ns/1ps
module baud_checker
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic peripheral_clock_enable,
    input wire logic modem_pins_present,
    input wire logic modem_controls_active,
    input wire logic sample_tick,
    input wire logic bit_tick,
    input wire logic sync_mode
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    property p_ready;
        psel && penable |-> pready;
    endproperty
    a_ready: assert property (p_ready) else $error("access not answered");
    property p_noerr;
        psel && penable |-> !pslverr;
    endproperty
    a_noerr: assert property (p_noerr) else $error("access refused");
    property p_modem;
        modem_controls_active == modem_pins_present;
    endproperty
    a_modem: assert property (p_modem) else $error("modem gating wrong");
    property p_freeze;
        !peripheral_clock_enable [*2] |-> !sample_tick && !bit_tick;
    endproperty
    a_freeze: assert property (p_freeze) else $error("tick while gated");
    property p_tick_cause;
        sample_tick |-> $past(peripheral_clock_enable);
    endproperty
    a_tick_cause: assert property (p_tick_cause) else $error("sample tick uncaused");
    property p_bit_cause;
        bit_tick |-> $past(peripheral_clock_enable);
    endproperty
    a_bit_cause: assert property (p_bit_cause) else $error("bit tick uncaused");
    property p_sync_eq;
        sync_mode && $past(sync_mode) |-> bit_tick == sample_tick;
    endproperty
    a_sync_eq: assert property (p_sync_eq) else $error("sync bit tick differs");
    // Async bit rate can never beat one eighth of the source
    property p_bit_gap;
        !sync_mode && !$past(sync_mode) && bit_tick |=> !bit_tick [*7];
    endproperty
    a_bit_gap: assert property (p_bit_gap) else $error("bit ticks too close");
    c_sample: cover property (sample_tick);
    c_async_bit: cover property (!sync_mode && bit_tick);
    c_sync_bit: cover property (sync_mode && bit_tick);
endmodule

bind serial_baud_rate_generator baud_checker chk_i
(
    .pclk,
    .presetn,
    .psel,
    .penable,
    .pready,
    .pslverr,
    .peripheral_clock_enable,
    .modem_pins_present,
    .modem_controls_active,
    .sample_tick,
    .bit_tick,
    .sync_mode
);

/* dv/ext_clock_source.sv */
`timescale 1ns/1ps
module ext_clock_source
#(
    parameter int half_ns = 30
)
(
    input wire logic run,
    output logic sclk
);
    // Phases of 3 cycles, period 6 cycles: above the 4.5 ratio
    initial sclk = 1'b0;
    always
    begin
        #half_ns;
        sclk = run ? ~sclk : 1'b0;
    end
endmodule

/* dv/testbench.sv */
`timescale 1ns/1ps
module testbench;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic peripheral_clock_enable, serial_clock_in, sclk_run;
    logic modem_pins_present, modem_controls_active;
    logic sample_tick, bit_tick, msb_first, sync_mode;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] char_bits;
    logic [2:0] parity_mode;
    logic [1:0] stop_bits;
    int n_fail, num_checks, c, k;
    localparam logic [7:0] mr = bit_rate_pkg::serial_mode_reg_offset;
    localparam logic [7:0] br = bit_rate_pkg::bit_rate_divider_reg_offset;

    serial_baud_rate_generator DUT (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .peripheral_clock_enable,
        .serial_clock_in, .modem_pins_present, .sample_tick, .bit_tick,
        .char_bits, .msb_first, .parity_mode, .stop_bits, .sync_mode,
        .modem_controls_active);
    ext_clock_source src (.run(sclk_run), .sclk(serial_clock_in));

    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    task close_out;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e)
        begin
            n_fail++;
            $display("wrong value at %0t: got %h want %h", $time, g, e);
        end
    endtask

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    // First tick after a reconfigure may be stale, so skip two
    task span(input logic b, input int n, output int cy);
        repeat (2)
            do @(posedge pclk); while ((b ? bit_tick : sample_tick) !== 1'b1);
        cy = 0;
        k = 0;
        while (k < n)
        begin
            @(posedge pclk);
            cy++;
            if ((b ? bit_tick : sample_tick) === 1'b1)
                k++;
        end
    endtask

    task rate(input logic [31:0] m, d, input logic b, input int n, e);
        apb(1'b1, mr, m);
        apb(1'b1, br, d);
        span(b, n, c);
        chk(c, e);
    endtask

    task t_regs;
        apb(1'b0, mr, 32'h0);
        chk(rd, bit_rate_pkg::serial_mode_reset);
        apb(1'b1, br, 32'h0004_0003);
        apb(1'b0, br, 32'h0);
        chk(rd, 32'h0004_0003);
        apb(1'b0, 8'h30, 32'h0);
        chk(rd, 32'h0);
    endtask

    task t_zero;
        apb(1'b1, mr, 32'h0008_0000);
        apb(1'b1, br, 32'h0);
        k = 0;
        repeat (64)
        begin
            @(posedge pclk);
            k += (sample_tick === 1'b1 || bit_tick === 1'b1);
        end
        chk(k, 0);
        apb(1'b1, mr, 32'h0008_0020);
        apb(1'b1, br, 32'h0000_0002);
        k = 0;
        repeat (64)
        begin
            @(posedge pclk);
            k += (sample_tick === 1'b1);
        end
        chk(k, 0);
    endtask

    task t_int;
        rate(32'h0008_0000, 2, 1'b0, 8, 16);
        rate(32'h0008_0000, 2, 1'b1, 2, 32);
        rate(32'h0000_0000, 2, 1'b1, 1, 32);
        rate(32'h0008_0000, 1, 1'b0, 8, 8);
        rate(32'h0008_0000, 1, 1'b1, 2, 16);
    endtask

    task t_src;
        rate(32'h0008_0010, 1, 1'b0, 4, 32);
        sclk_run = 1'b1;
        rate(32'h0008_0030, 2, 1'b0, 4, 48);
        rate(32'h0000_0130, 5, 1'b1, 4, 24);
        sclk_run = 1'b0;
    endtask

    task t_frac;
        rate(32'h0008_0000, 32'h0004_0002, 1'b0, 8, 20);
        rate(32'h0008_0001, 32'h0004_0002, 1'b0, 8, 16);
        rate(32'h0008_0000, 32'h0004_0001, 1'b0, 8, 12);
        rate(32'h0000_0100, 32'h0004_0003, 1'b1, 4, 12);
    endtask

    task t_freeze;
        rate(32'h0008_0000, 8, 1'b0, 1, 8);
        repeat (3) @(posedge pclk);
        peripheral_clock_enable <= 1'b0;
        k = 0;
        repeat (20)
        begin
            @(posedge pclk);
            k += (sample_tick === 1'b1);
        end
        peripheral_clock_enable <= 1'b1;
        chk(k, 0);
        // Four of eight source cycles ran before the gate; four remain, then one for the registered tick
        c = 0;
        do
        begin
            @(posedge pclk);
            c++;
        end
        while (sample_tick !== 1'b1 && c < 20);
        chk(c, 5);
    endtask

    task t_fields;
        for (int p = 0; p < 6; p++)
        begin
            apb(1'b1, mr, p << 9);
            chk(parity_mode, p > 4 ? 4 : p);
        end
        modem_pins_present <= 1'b1;
        apb(1'b1, mr, 32'h0001_00c0);
        chk(modem_controls_active, 1'b1);
        chk({char_bits, msb_first}, {4'h8, 1'b1});
        apb(1'b1, mr, 32'h0002_0000);
        chk(char_bits, 4'h9);
        apb(1'b1, mr, 32'h0000_1000);
        chk(stop_bits, 2'h1);
        apb(1'b1, mr, 32'h0000_1100);
        chk(stop_bits, 2'h0);
        apb(1'b1, mr, 32'h0000_3000);
        chk(stop_bits, 2'h0);
        modem_pins_present <= 1'b0;
    endtask

    initial
    begin
        #200000;
        n_fail++;
        close_out;
    end

    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        peripheral_clock_enable = 1'b0;
        sclk_run = 1'b0;
        modem_pins_present = 1'b0;
        n_fail = 0;
        num_checks = 0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_regs;
        peripheral_clock_enable <= 1'b1;
        t_zero;
        t_int;
        t_src;
        t_frac;
        t_freeze;
        t_fields;
        close_out;
    end
endmodule

/* include/bit_rate_pkg.sv */
package bit_rate_pkg;

    // Register byte offsets
    localparam logic [7:0] serial_mode_reg_offset = 8'h04;
    localparam logic [7:0] bit_rate_divider_reg_offset = 8'h20;
    localparam logic [7:0] status_reg_offset = 8'h14;

    // serial_mode_reg fields
    localparam int clock_source_select_pos = 4;
    localparam int char_length_pos = 6;
    localparam int sync_mode_pos = 8;
    localparam int parity_pos = 9;
    localparam int stop_bits_pos = 12;
    localparam int msb_first_pos = 16;
    localparam int nine_bit_pos = 17;
    localparam int oversample_pos = 19;
    localparam int special_mode_pos = 0;

    // bit_rate_divider_reg fields
    localparam int integer_divider_pos = 0;
    localparam int fractional_part_pos = 16;

    localparam logic [31:0] serial_mode_reset = 32'h0000_0000;
    localparam logic [15:0] integer_divider_reset = 16'h0000;
    localparam logic [2:0] fractional_part_reset = 3'h0;

    // Fixed prescale of the master clock for source select 1
    localparam logic [3:0] fixed_prescale = 4'h8;
    localparam logic [4:0] oversample_16 = 5'h10;
    localparam logic [4:0] oversample_8 = 5'h08;
    localparam logic [2:0] fraction_steps = 3'h7;

    typedef enum logic [1:0]
    {
        src_master = 2'h0,
        src_prescaled = 2'h1,
        src_reserved = 2'h2,
        src_external = 2'h3
    } clock_source_t;

    typedef enum logic [2:0]
    {
        par_even = 3'h0,
        par_odd = 3'h1,
        par_space = 3'h2,
        par_mark = 3'h3,
        par_none = 3'h4
    } parity_t;

endpackage

/* verilog/ext_clock_sync.sv */
`timescale 1ns/1ps
// Serial clock pin synchroniser with rising edge detect
module ext_clock_sync
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic serial_clock_in,
    output logic rise
);
    logic meta;
    logic stable;
    logic prev;
    logic next_meta;
    logic next_stable;
    logic next_prev;

    always_comb
    begin
        next_meta = serial_clock_in;
        next_stable = meta;
        next_prev = stable;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            meta <= 1'b0;
            stable <= 1'b0;
            prev <= 1'b0;
        end
        else
        begin
            meta <= next_meta;
            stable <= next_stable;
            prev <= next_prev;
        end
    end

    // Edges are only seen if each phase outlasts a pclk period
    assign rise = stable & ~prev;
endmodule

/* verilog/serial_baud_rate_generator.sv */
`timescale 1ns/1ps
// How it works
// - Source is master clock, master clock divided by 8, or serial clock pin.
// - Selected source is divided by a sixteen-bit integer divider.
// - Divider zero stops all bit-period ticks, except source three in sync mode.
// - Divider one passes the selected source straight through unless a fraction applies.
// - Async mode: divided clock samples, then divided by 16 or 8 for bits.
// - Oversampling bit one gives x8 sampling, zero gives x16.
// - Async bit rate is source over 8 times (2-over) times divider.
// - Nonzero fraction adds fraction/8 to the divider.
// - Fractional division only in async normal mode, not sync or special modes.
// - Character length five to nine bits, MSB or LSB first.
// - Stop bits 1, 1.5, 2 async; only 1 or 2 synchronous.
// - Parity even, odd, mark, space or none.
// - Modem bits for absent pins change nothing.
// - Gated clock resumes from the exact held state.
// - Configuration writes accepted while the clock enable is off.
// - Sync mode bit rate is selected clock over divider only, except source three.
// - Source three in sync mode uses pin clock directly, divider ignored.
module serial_baud_rate_generator
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic peripheral_clock_enable,
    input wire logic serial_clock_in,
    input wire logic modem_pins_present,
    output logic sample_tick,
    output logic bit_tick,
    output logic [3:0] char_bits,
    output logic msb_first,
    output logic [2:0] parity_mode,
    output logic [1:0] stop_bits,
    output logic sync_mode,
    output logic modem_controls_active
);
    logic [31:0] serial_mode_reg;
    logic [15:0] integer_divider;
    logic [2:0] fractional_part;
    logic [31:0] next_serial_mode_reg;
    logic [15:0] next_integer_divider;
    logic [2:0] next_fractional_part;
    logic [3:0] pre_count;
    logic [3:0] next_pre_count;
    logic [15:0] div_count;
    logic [15:0] next_div_count;
    logic [2:0] frac_phase;
    logic [2:0] next_frac_phase;
    logic [4:0] over_count;
    logic [4:0] next_over_count;
    logic sample_q;
    logic next_sample_q;
    logic bit_q;
    logic next_bit_q;
    logic [31:0] next_prdata;
    logic ext_rise;
    logic src_tick;
    logic div_tick;
    logic [15:0] div_limit;
    logic extra_cycle;
    logic [1:0] src_sel;
    logic oversample8;
    logic special_mode;
    logic wr_en;

    ext_clock_sync u_sync
    (
        .pclk(pclk),
        .presetn(presetn),
        .serial_clock_in(serial_clock_in),
        .rise(ext_rise)
    );

    // APB slave, zero wait state
    assign pready = 1'b1;
    assign pslverr = 1'b0;
    // Register writes bypass the clock enable so setup works while gated
    assign wr_en = psel & penable & pwrite;

    always_comb
    begin
        next_serial_mode_reg = serial_mode_reg;
        next_integer_divider = integer_divider;
        next_fractional_part = fractional_part;
        next_prdata = prdata;
        if (wr_en && paddr == bit_rate_pkg::serial_mode_reg_offset)
        begin
            next_serial_mode_reg = pwdata;
        end
        if (wr_en && paddr == bit_rate_pkg::bit_rate_divider_reg_offset)
        begin
            next_integer_divider = pwdata[bit_rate_pkg::integer_divider_pos +: 16];
            next_fractional_part = pwdata[bit_rate_pkg::fractional_part_pos +: 3];
        end
        if (psel && !penable && !pwrite)
        begin
            case (paddr)
                bit_rate_pkg::serial_mode_reg_offset:
                    next_prdata = serial_mode_reg;
                bit_rate_pkg::bit_rate_divider_reg_offset:
                    next_prdata = {13'h0000, fractional_part, integer_divider};
                bit_rate_pkg::status_reg_offset:
                    next_prdata = {27'h0000000, over_count};
                default:
                    next_prdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            serial_mode_reg <= bit_rate_pkg::serial_mode_reset;
            integer_divider <= bit_rate_pkg::integer_divider_reset;
            fractional_part <= bit_rate_pkg::fractional_part_reset;
            prdata <= 32'h0000_0000;
        end
        else
        begin
            serial_mode_reg <= next_serial_mode_reg;
            integer_divider <= next_integer_divider;
            fractional_part <= next_fractional_part;
            prdata <= next_prdata;
        end
    end

    assign src_sel = serial_mode_reg[bit_rate_pkg::clock_source_select_pos +: 2];
    assign sync_mode = serial_mode_reg[bit_rate_pkg::sync_mode_pos];
    assign oversample8 = serial_mode_reg[bit_rate_pkg::oversample_pos];
    assign special_mode = serial_mode_reg[bit_rate_pkg::special_mode_pos +: 4] != 4'h0;

    // Frame format decode
    always_comb
    begin
        // 9 bits override the length field
        if (serial_mode_reg[bit_rate_pkg::nine_bit_pos])
        begin
            char_bits = 4'h9;
        end
        else
        begin
            char_bits = 4'h5 + {2'h0, serial_mode_reg[bit_rate_pkg::char_length_pos +: 2]};
        end
        msb_first = serial_mode_reg[bit_rate_pkg::msb_first_pos];
        case (serial_mode_reg[bit_rate_pkg::parity_pos +: 3])
            3'h0, 3'h1, 3'h2, 3'h3:
                parity_mode = serial_mode_reg[bit_rate_pkg::parity_pos +: 3];
            default:
                parity_mode = bit_rate_pkg::par_none;
        endcase
        stop_bits = serial_mode_reg[bit_rate_pkg::stop_bits_pos +: 2];
        // 1.5 stop bits not allowed in synchronous mode
        if (stop_bits == 2'h1 && sync_mode)
        begin
            stop_bits = 2'h0;
        end
        else if (stop_bits == 2'h3)
        begin
            stop_bits = 2'h0;
        end
    end

    assign modem_controls_active = modem_pins_present;

    // Source select; all counters freeze when gated, so work resumes in place
    always_comb
    begin
        next_pre_count = pre_count;
        src_tick = 1'b0;
        if (peripheral_clock_enable)
        begin
            case (bit_rate_pkg::clock_source_t'(src_sel))
                bit_rate_pkg::src_master:
                    src_tick = 1'b1;
                bit_rate_pkg::src_prescaled:
                begin
                    if (pre_count == bit_rate_pkg::fixed_prescale - 4'h1)
                    begin
                        next_pre_count = 4'h0;
                        src_tick = 1'b1;
                    end
                    else
                    begin
                        next_pre_count = pre_count + 4'h1;
                    end
                end
                bit_rate_pkg::src_external:
                    src_tick = ext_rise;
                default:
                    src_tick = 1'b0;
            endcase
        end
    end

    // Fraction: first fractional_part of each 8 periods count one extra
    assign extra_cycle = fractional_part != 3'h0 && !special_mode && !sync_mode
        && frac_phase < fractional_part;
    assign div_limit = extra_cycle ? integer_divider : integer_divider - 16'h0001;

    always_comb
    begin
        next_div_count = div_count;
        next_frac_phase = frac_phase;
        div_tick = 1'b0;
        if (sync_mode && bit_rate_pkg::clock_source_t'(src_sel) == bit_rate_pkg::src_external)
        begin
            div_tick = src_tick;
        end
        else if (integer_divider == 16'h0000)
        begin
            div_tick = 1'b0;
            next_div_count = 16'h0000;
        end
        else if (integer_divider == 16'h0001 && !extra_cycle)
        begin
            div_tick = src_tick;
            // Phase must advance here too, or the stretch never recurs
            if (src_tick)
            begin
                next_frac_phase = frac_phase + 3'h1;
            end
        end
        else if (src_tick)
        begin
            if (div_count >= div_limit)
            begin
                next_div_count = 16'h0000;
                div_tick = 1'b1;
                next_frac_phase = frac_phase + 3'h1;
            end
            else
            begin
                next_div_count = div_count + 16'h0001;
            end
        end
    end

    // Oversampling stage
    always_comb
    begin
        next_over_count = over_count;
        next_sample_q = 1'b0;
        next_bit_q = 1'b0;
        if (div_tick)
        begin
            next_sample_q = 1'b1;
            if (sync_mode)
            begin
                next_bit_q = 1'b1;
            end
            else if (over_count >= (oversample8 ? bit_rate_pkg::oversample_8
                : bit_rate_pkg::oversample_16) - 5'h01)
            begin
                next_over_count = 5'h00;
                next_bit_q = 1'b1;
            end
            else
            begin
                next_over_count = over_count + 5'h01;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pre_count <= 4'h0;
            div_count <= 16'h0000;
            frac_phase <= 3'h0;
            over_count <= 5'h00;
            sample_q <= 1'b0;
            bit_q <= 1'b0;
        end
        else
        begin
            pre_count <= next_pre_count;
            div_count <= next_div_count;
            frac_phase <= next_frac_phase;
            over_count <= next_over_count;
            sample_q <= next_sample_q;
            bit_q <= next_bit_q;
        end
    end

    assign sample_tick = sample_q;
    assign bit_tick = bit_q;
endmodule
